// [hdl/pdr_coarse_tracker.sv]
// Coarse phase detector: counts whole input cycles of phase within a set range
`timescale 1ns/100ps
module pdr_coarse_tracker #(
    parameter int COARSE_W = pdr_pkg::PDR_COARSE_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [3:0] limit_code,
    input wire pdr_pkg::pdr_wrap_s wrap,
    output logic signed [COARSE_W-1:0] cycles,
    output logic beyond_limit
);

    typedef struct packed {
        logic signed [COARSE_W-1:0] cnt;
        logic beyond;
    } pdr_trk_s;

    pdr_trk_s s_q;
    pdr_trk_s s_d;
    logic signed [COARSE_W-1:0] lim;

    ////////////////////////////////////////////////////////////////////////
    // Range from the coarse-limit code: +-(2^(n+1)-1) cycles, held at 8191 for codes 12 and up
    // RULE2 - range from code
    always_comb
    begin
        if (limit_code >= pdr_pkg::PDR_LIMIT_SAT_CODE)
            lim = COARSE_W'(pdr_pkg::PDR_LIMIT_MAX);
        else
            lim = COARSE_W'((32'd1 << (32'(limit_code) + 32'd1)) - 32'd1);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d = s_q;
        s_d.beyond = 1'b0;
        // RULE1 - disabled detector cleared
        if (!enable)
        begin
            s_d.cnt = '0;
        end
        else if (wrap.up && !wrap.dn)
        begin
            // Saturate rather than wrap, so the sign stays trustworthy
            if (s_q.cnt >= lim)
            begin
                s_d.cnt = lim;
                s_d.beyond = 1'b1;
            end
            else
                s_d.cnt = s_q.cnt + COARSE_W'(1);
        end
        else if (wrap.dn && !wrap.up)
        begin
            if (s_q.cnt <= -lim)
            begin
                s_d.cnt = -lim;
                s_d.beyond = 1'b1;
            end
            else
                s_d.cnt = s_q.cnt - COARSE_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cycles = s_q.cnt;
    assign beyond_limit = s_q.beyond;

endmodule // pdr_coarse_tracker

// [hdl/pdr_pkg.sv]
// Constants and carrier types for the main loop phase detector range control
package pdr_pkg;

    // Configuration register location and reset value
    localparam logic [7:0] PDR_CFG_ADDR = 8'h74;
    localparam logic [7:0] PDR_CFG_RESET = 8'h85;
    // Bit 4 is unused and always reads zero
    localparam logic [7:0] PDR_CFG_MASK = 8'hEF;

    // Field positions in the configuration register
    localparam int PDR_BIT_LOSS_EN = 7;
    localparam int PDR_BIT_WIDE_EN = 6;
    localparam int PDR_BIT_COARSE_SEL = 5;
    localparam int PDR_LIMIT_LSB = 0;
    localparam int PDR_LIMIT_W = 4;

    // Coarse range: codes at or above this saturate at the widest range
    localparam logic [3:0] PDR_LIMIT_SAT_CODE = 4'hC;
    localparam int PDR_COARSE_W = 14;
    localparam logic [PDR_COARSE_W-1:0] PDR_LIMIT_MAX = 14'h1FFF;
    // Fraction bits of one input cycle in the fine phase word
    localparam int PDR_FRAC_W = 10;

    // Register port request, all on the system clock
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdr_reg_req_s;

    // Whole-cycle slips reported by the fine detector
    typedef struct packed {
        logic up;
        logic dn;
    } pdr_wrap_s;

endpackage

// [hdl/pdr_range_ctrl.sv]
// Main loop phase detector range control: configuration register and loop error select
//
// Functional notes
// RULE1 - Wide-range bit set enables wide-range phase and lock detectors; clear disables them.
// RULE2 - Wide-range tracking range comes from the coarse-limit field, bits 3:0.
// RULE3 - Coarse select clear: loop error limited to one cycle, coarse count still kept.
// RULE4 - Coarse select set: loop also uses coarse result, up to 8191 cycles of phase.
// RULE5 - Software may set coarse select for direct lock on fast inputs.
// RULE6 - Software sets wide-range enable whenever it sets coarse select.
`timescale 1ns/100ps
module pdr_range_ctrl #(
    parameter int COARSE_W = pdr_pkg::PDR_COARSE_W,
    parameter int FRAC_W = pdr_pkg::PDR_FRAC_W,
    parameter int ERR_W = COARSE_W + FRAC_W + 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pdr_pkg::pdr_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic signed [FRAC_W:0] fine_phase,
    input wire pdr_pkg::pdr_wrap_s fine_wrap,
    output logic signed [ERR_W-1:0] loop_phase_err,
    output logic wide_range_active,
    output logic coarse_result_to_loop,
    output logic coarse_loss_en,
    output logic [3:0] coarse_limit,
    output logic signed [COARSE_W-1:0] coarse_cycles,
    output logic coarse_beyond_limit
);

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic signed [ERR_W-1:0] err;
        logic signed [COARSE_W-1:0] cycles;
        logic beyond;
    } pdr_state_s;

    pdr_state_s s_q;
    pdr_state_s s_d;
    logic signed [COARSE_W-1:0] trk_cycles;
    logic trk_beyond;
    logic wide_en;
    logic sel_bit;
    logic use_coarse;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // Field decode from the stored register; address match from the incoming request
    assign wide_en = s_q.cfg[pdr_pkg::PDR_BIT_WIDE_EN];
    assign sel_bit = s_q.cfg[pdr_pkg::PDR_BIT_COARSE_SEL];
    assign hit = (reg_req.addr == pdr_pkg::PDR_CFG_ADDR);
    // RULE6 - coarse needs wide range
    // A select without the wide-range detector would feed a frozen zero count
    assign use_coarse = sel_bit & wide_en;

    ////////////////////////////////////////////////////////////////////////
    // Coarse cycle counter, alive only while the wide-range detector is on
    // RULE1 - wide range gating
    pdr_coarse_tracker #(
        .COARSE_W(COARSE_W)
    ) u_tracker (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(wide_en),
        .limit_code(s_q.cfg[pdr_pkg::PDR_LIMIT_LSB +: pdr_pkg::PDR_LIMIT_W]),
        .wrap(fine_wrap),
        .cycles(trk_cycles),
        .beyond_limit(trk_beyond)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d = s_q;

        // Register write; unused bit 4 is never stored
        if (reg_req.wr && hit)
            s_d.cfg = reg_req.wdata & pdr_pkg::PDR_CFG_MASK;

        // Read data held until the next read; unmapped reads give zero
        if (reg_req.rd)
            s_d.rdata = hit ? s_q.cfg : 8'h00;

        // RULE4 - coarse plus fine
        if (use_coarse)
            s_d.err = (ERR_W'(trk_cycles) <<< FRAC_W) + ERR_W'(fine_phase);
        // RULE3 - one cycle limit
        else
            s_d.err = ERR_W'(fine_phase);

        // RULE3 - coarse count retained
        s_d.cycles = trk_cycles;
        s_d.beyond = trk_beyond;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.cfg <= pdr_pkg::PDR_CFG_RESET;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // All outputs straight from state flip-flops
    assign reg_rdata = s_q.rdata;
    assign loop_phase_err = s_q.err;
    assign wide_range_active = s_q.cfg[pdr_pkg::PDR_BIT_WIDE_EN];
    assign coarse_result_to_loop = s_q.cfg[pdr_pkg::PDR_BIT_COARSE_SEL];
    assign coarse_loss_en = s_q.cfg[pdr_pkg::PDR_BIT_LOSS_EN];
    assign coarse_limit = s_q.cfg[pdr_pkg::PDR_LIMIT_LSB +: pdr_pkg::PDR_LIMIT_W];
    assign coarse_cycles = s_q.cycles;
    assign coarse_beyond_limit = s_q.beyond;

endmodule // pdr_range_ctrl

// [test/pdr_range_ctrl_sva.sv]
// Port checker for the range control block
`timescale 1ns/100ps
module pdr_range_ctrl_sva #(
    parameter int COARSE_W = 14,
    parameter int FRAC_W = 10,
    parameter int ERR_W = 25
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pdr_pkg::pdr_reg_req_s reg_req,
    input wire logic signed [FRAC_W:0] fine_phase,
    input wire logic signed [ERR_W-1:0] loop_phase_err,
    input wire logic wide_range_active,
    input wire logic coarse_result_to_loop,
    input wire logic [3:0] coarse_limit,
    input wire logic signed [COARSE_W-1:0] coarse_cycles
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire cfg_wr = reg_req.wr && reg_req.addr == pdr_pkg::PDR_CFG_ADDR;
    a_wide_bit_write: assert property (cfg_wr |=> wide_range_active == $past(reg_req.wdata[6]))
        else $error("wide range bit wrong");
    a_wide_off_zero: assert property (!wide_range_active [*3] |-> coarse_cycles == 0)
        else $error("count kept while disabled");
    a_limit_write: assert property (cfg_wr |=> coarse_limit == $past(reg_req.wdata[3:0]))
        else $error("coarse limit wrong");
    a_fine_only_err: assert property (!(wide_range_active && coarse_result_to_loop) [*2] |->
        loop_phase_err == $past(fine_phase)) else $error("fine error wrong");
    a_coarse_err: assert property ((wide_range_active && coarse_result_to_loop) [*2] |->
        loop_phase_err == (coarse_cycles <<< FRAC_W) + $past(fine_phase)) else $error("coarse error wrong");
    c_coarse_mode: cover property (wide_range_active && coarse_result_to_loop && coarse_cycles != 0);
    c_wide_off: cover property (!wide_range_active && cfg_wr);
    c_neg_count: cover property (coarse_cycles < 0);
endmodule // pdr_range_ctrl_sva
bind pdr_range_ctrl pdr_range_ctrl_sva #(.COARSE_W(COARSE_W), .FRAC_W(FRAC_W), .ERR_W(ERR_W)) u_sva (.clk(clk),
    .sys_rst(sys_rst), .reg_req(reg_req), .fine_phase(fine_phase), .loop_phase_err(loop_phase_err),
    .wide_range_active(wide_range_active), .coarse_result_to_loop(coarse_result_to_loop),
    .coarse_limit(coarse_limit), .coarse_cycles(coarse_cycles));

// [test/tb_top.sv]
// Self-checking bench for the range control block
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    pdr_pkg::pdr_reg_req_s req = '0;
    pdr_pkg::pdr_wrap_s wrap = '0;
    logic signed [10:0] fine = '0;
    logic signed [24:0] err;
    logic signed [13:0] cyc;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [3:0] lim;
    logic wide, sel, loss, beyond;
    int err_count = 0;
    int checks = 0;
    int code, n, dir, exp_c, sat, beyond_n;
    always #2.5 clk = ~clk;
    // Beyond-limit pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk)
    begin
        if (beyond === 1'b1)
            beyond_n++;
    end
    pdr_range_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .fine_phase(fine),
        .fine_wrap(wrap), .loop_phase_err(err), .wide_range_active(wide), .coarse_result_to_loop(sel),
        .coarse_loss_en(loss), .coarse_limit(lim), .coarse_cycles(cyc), .coarse_beyond_limit(beyond));
    task automatic tick(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        tick();
        req = '0;
        // Idle edge so the next request never lands in this time step
        tick();
    endtask
    task automatic chk_reset;
        check({loss, wide, sel, lim}, {pdr_pkg::PDR_CFG_RESET[7:5], pdr_pkg::PDR_CFG_RESET[3:0]});
        check(cyc, 0);
        check(err, 0);
        check({beyond, rdata}, 9'h000);
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        req = '{1'b0, 1'b1, a, 8'h00};
        tick();
        req = '0;
        tick();
        check(rdata, e);
    endtask
    function automatic logic signed [24:0] exp_err(int c, logic signed [10:0] f, logic both);
        return both ? c * 1024 + f : f;
    endfunction
    task automatic print_verdict;
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #50000;
        err_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(36));
        tick(3);
        sys_rst = 1'b0;
        chk_reset();
        rd_chk(8'h74, 8'h85);
        // All-zero and all-one first, then random patterns
        for (int i = 0; i < 12; i++)
        begin
            v = (i < 2) ? {8{i[0]}} : 8'($urandom);
            wr(8'h74, v);
            check({loss, wide, sel, lim}, {v[7], v[6], v[5], v[3:0]});
            rd_chk(8'h74, v & 8'hEF);
        end
        wr(8'h70, 8'hFF);
        rd_chk(8'h70, 8'h00);
        rd_chk(8'h74, v & 8'hEF);
        repeat (8)
        begin
            code = $urandom_range(2);
            n = $urandom_range(8);
            dir = $urandom_range(1);
            wr(8'h74, 8'h00);
            tick(3);
            wr(8'h74, {4'h6, code[3:0]});
            beyond_n = 0;
            // Slips beyond the range saturate at 2^(code+1)-1
            repeat (n)
            begin
                wrap = dir ? 2'b01 : 2'b10;
                tick();
                wrap = '0;
                tick();
            end
            sat = 2 ** (code + 1) - 1;
            exp_c = (n < sat ? n : sat) * (dir ? -1 : 1);
            tick(3);
            check(cyc, exp_c);
            check(beyond_n, n > sat ? n - sat : 0);
            fine = 11'($urandom);
            tick(2);
            check(err, exp_err(exp_c, fine, 1'b1));
            wr(8'h74, {4'h4, code[3:0]});
            tick(2);
            check(cyc, exp_c);
            check(err, exp_err(exp_c, fine, 1'b0));
            wr(8'h74, 8'h20);
            wrap = 2'b10;
            tick();
            wrap = '0;
            tick(3);
            check(cyc, 0);
            check(err, exp_err(0, fine, 1'b0));
        end
        // Reset in mid-run returns every field to its default
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        chk_reset();
        rd_chk(8'h74, 8'h85);
        print_verdict();
    end
endmodule // tb_top
